// file: include/async_rx_defs.vh
// constants for the asynchronous serial receiver
`ifndef ASYNC_RX_DEFS_VH
`define ASYNC_RX_DEFS_VH
// samples per bit and voting positions, normal speed
`define NORM_SAMPLES 5'h10
`define NORM_VOTE_FIRST 5'h08
`define NORM_VOTE_MID 5'h09
`define NORM_VOTE_LAST 5'h0a
// samples per bit and voting positions, double speed
`define DBL_SAMPLES 5'h08
`define DBL_VOTE_FIRST 5'h04
`define DBL_VOTE_MID 5'h05
`define DBL_VOTE_LAST 5'h06
// parity mode bit positions
`define PAR_ENABLE_BIT 1
`define PAR_ODD_BIT 0
// buffer depth
`define RX_BUF_DEPTH 2
// reset value of the baud divisor
`define BAUD_DIV_RESET 16'h0000
`endif

// file: rtl/rx_char_store.v
// two-entry character store with registered read data
`timescale 1ns/1ps
module rx_char_store #(
  parameter WIDTH = 12
) (
  // clock
  input wire clk,
  // write side
  input wire wr_en,
  input wire wr_addr,
  input wire [WIDTH-1:0] wr_data,
  // read side
  input wire rd_addr,
  output reg [WIDTH-1:0] rd_data
);

  reg [WIDTH-1:0] mem_reg [0:1];

  // storage write and registered read
  always @(posedge clk) begin
    if (wr_en) begin
      mem_reg[wr_addr] <= wr_data;
    end
    rd_data <= (wr_en && (wr_addr == rd_addr)) ? wr_data : mem_reg[rd_addr];
  end

endmodule

// file: rtl/async_serial_receiver.v
// asynchronous serial receiver with oversampling, voting and two-deep buffer
`timescale 1ns/1ps
`include "async_rx_defs.vh"
module async_serial_receiver #(
  parameter DIV_WIDTH = 16
) (
  // clock and reset
  input wire CORE_CLK,
  input wire RST,
  // serial line
  input wire SERIAL_IN_PIN,
  output reg PIN_OVERRIDE,
  // configuration
  input wire RECEIVER_ENABLE,
  input wire RX_COMPLETE_IRQ_ENABLE,
  input wire DOUBLE_SPEED_SELECT,
  input wire [1:0] PARITY_MODE_BITS,
  input wire STOP_BITS_SELECT,
  input wire [3:0] DATA_BITS,
  input wire [DIV_WIDTH-1:0] BAUD_DIVISOR,
  // data read
  input wire DATA_READ,
  output reg [8:0] DATA_BUFFER_PORT,
  // status
  output reg RX_COMPLETE_FLAG,
  output reg FRAME_ERROR_FLAG,
  output reg OVERRUN_FLAG,
  output reg PARITY_ERROR_FLAG,
  output reg RX_COMPLETE_IRQ
);

  // ---------------------------------------------------------------
  // frame states
  // ---------------------------------------------------------------
  localparam ST_IDLE = 2'h0;
  localparam ST_START = 2'h1;
  localparam ST_BITS = 2'h2;
  localparam ST_HOLD = 2'h3;

  // majority of three samples
  function maj3;
    input [2:0] s;
    begin
      maj3 = (s[0] & s[1]) | (s[0] & s[2]) | (s[1] & s[2]);
    end
  endfunction

  // ---------------------------------------------------------------
  // oversampling tick
  // ---------------------------------------------------------------
  reg [DIV_WIDTH-1:0] div_reg;
  reg tick_reg;

  // divide the core clock down to the sample rate
  always @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      div_reg <= `BAUD_DIV_RESET;
      tick_reg <= 1'b0;
    end else if (!RECEIVER_ENABLE || div_reg == {DIV_WIDTH{1'b0}}) begin
      div_reg <= BAUD_DIVISOR;
      tick_reg <= RECEIVER_ENABLE;
    end else begin
      div_reg <= div_reg - {{(DIV_WIDTH-1){1'b0}}, 1'b1};
      tick_reg <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // bit recovery
  // ---------------------------------------------------------------
  wire [4:0] n_samples = DOUBLE_SPEED_SELECT ? `DBL_SAMPLES : `NORM_SAMPLES;
  wire [4:0] v_first = DOUBLE_SPEED_SELECT ? `DBL_VOTE_FIRST : `NORM_VOTE_FIRST;
  wire [4:0] v_mid = DOUBLE_SPEED_SELECT ? `DBL_VOTE_MID : `NORM_VOTE_MID;
  wire [4:0] v_last = DOUBLE_SPEED_SELECT ? `DBL_VOTE_LAST : `NORM_VOTE_LAST;
  wire par_on = PARITY_MODE_BITS[`PAR_ENABLE_BIT];
  wire [3:0] frame_bits = DATA_BITS + {3'h0, par_on} + 4'h1; // data, parity, one stop

  reg [1:0] state_reg;
  reg [4:0] samp_reg;
  reg [3:0] bitn_reg;
  reg [2:0] vote_reg;
  reg prev_reg;
  reg [10:0] shift_reg;
  reg frame_done;
  reg [11:0] held_reg;
  reg held_valid_reg;
  reg pend_ovr_reg;

  wire bit_val = maj3({vote_reg[1:0], SERIAL_IN_PIN});
  wire at_last = tick_reg && samp_reg == v_last;

  // assemble the completed character with its status
  reg [8:0] data_bits_w;
  reg par_bit_w;
  reg stop_bit_w;
  reg par_calc_w;
  integer i;
  always @* begin
    data_bits_w = 9'h000;
    par_calc_w = PARITY_MODE_BITS[`PAR_ODD_BIT];
    for (i = 0; i < 9; i = i + 1) begin
      if (i < DATA_BITS) begin
        data_bits_w[i] = shift_reg[i];
        par_calc_w = par_calc_w ^ shift_reg[i];
      end
    end
    par_bit_w = shift_reg[DATA_BITS];
    stop_bit_w = bit_val;
  end
  wire [11:0] new_char = {~stop_bit_w, pend_ovr_reg,
                          par_on & (par_calc_w ^ par_bit_w), data_bits_w};

  // buffer occupancy
  reg [1:0] count_reg;
  reg rd_ptr_reg;
  reg wr_ptr_reg;
  wire buf_full = count_reg == 2'h2;
  wire pop = DATA_READ && count_reg != 2'h0;
  wire push_free = !buf_full || pop;

  // recovery state machine
  always @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      state_reg <= ST_IDLE;
      samp_reg <= 5'h00;
      bitn_reg <= 4'h0;
      vote_reg <= 3'h0;
      prev_reg <= 1'b1;
      shift_reg <= 11'h000;
      frame_done <= 1'b0;
    end else if (!RECEIVER_ENABLE) begin
      state_reg <= ST_IDLE; // abandon frame
      samp_reg <= 5'h00;
      bitn_reg <= 4'h0;
      prev_reg <= 1'b1;
      frame_done <= 1'b0;
    end else begin
      frame_done <= 1'b0;
      if (tick_reg) begin
        prev_reg <= SERIAL_IN_PIN;
        if (samp_reg == v_first || samp_reg == v_mid) begin
          vote_reg <= {vote_reg[1:0], SERIAL_IN_PIN};
        end
        samp_reg <= (samp_reg == n_samples) ? 5'h01 : samp_reg + 5'h01;
      end
      case (state_reg)
        ST_IDLE: begin
          if (tick_reg && prev_reg && !SERIAL_IN_PIN) begin
            state_reg <= ST_START;
            samp_reg <= 5'h02; // first low sample was sample 1
            vote_reg <= 3'h0;
          end
        end
        ST_START: begin
          if (at_last) begin
            if (bit_val) begin
              state_reg <= ST_IDLE; // noise spike
            end else begin
              state_reg <= ST_BITS;
              bitn_reg <= 4'h0;
            end
          end
        end
        ST_BITS: begin
          if (at_last) begin
            if (bitn_reg == frame_bits - 4'h1) begin
              frame_done <= 1'b1; // stop bit voted, frame complete
              state_reg <= ST_IDLE; // next edge may follow at once
              prev_reg <= 1'b1;
            end else begin
              shift_reg[bitn_reg] <= bit_val;
              bitn_reg <= bitn_reg + 4'h1;
            end
          end
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  // an accepted start bit, used to detect overrun
  wire start_accept = state_reg == ST_START && at_last && !bit_val && RECEIVER_ENABLE;
  reg [11:0] done_char_reg;

  // capture the finished character for the buffer or the hold stage
  always @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      done_char_reg <= 12'h000;
    end else if (state_reg == ST_BITS && at_last) begin
      done_char_reg <= new_char;
    end
  end

  // ---------------------------------------------------------------
  // hold stage, overrun and buffer control
  // ---------------------------------------------------------------
  wire from_hold = held_valid_reg && push_free;
  wire from_frame = frame_done && !held_valid_reg && push_free;
  wire push = from_hold || from_frame;
  wire [11:0] push_char = from_hold ? held_reg : done_char_reg;

  // hold stage is the shifter copy; overrun on new start while buffer and hold stage are full
  always @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      held_reg <= 12'h000;
      held_valid_reg <= 1'b0;
      pend_ovr_reg <= 1'b0;
    end else if (!RECEIVER_ENABLE) begin
      held_valid_reg <= 1'b0;
      pend_ovr_reg <= 1'b0;
    end else begin
      if (from_hold) begin
        held_valid_reg <= 1'b0;
      end else if (frame_done && !push_free && !held_valid_reg) begin
        held_reg <= done_char_reg;
        held_valid_reg <= 1'b1;
      end
      if (start_accept && buf_full && held_valid_reg && !pop) begin
        pend_ovr_reg <= 1'b1;
        held_reg[10] <= 1'b1; // report on next written character
      end else if (from_frame || from_hold) begin
        pend_ovr_reg <= 1'b0;
      end
    end
  end

  // buffer pointers; flush on disable
  always @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      count_reg <= 2'h0;
      rd_ptr_reg <= 1'b0;
      wr_ptr_reg <= 1'b0;
    end else if (!RECEIVER_ENABLE) begin
      count_reg <= 2'h0;
      rd_ptr_reg <= 1'b0;
      wr_ptr_reg <= 1'b0;
    end else begin
      if (push) begin
        wr_ptr_reg <= ~wr_ptr_reg;
      end
      if (pop) begin
        rd_ptr_reg <= ~rd_ptr_reg; // read advances the buffer
      end
      count_reg <= count_reg + {1'b0, push} - {1'b0, pop};
    end
  end

  wire [11:0] head_char;
  wire head_addr = pop ? ~rd_ptr_reg : rd_ptr_reg; // head entry after this cycle's read
  rx_char_store #(
    .WIDTH(12)
  ) u_store (
    .clk(CORE_CLK),
    .wr_en(push),
    .wr_addr(wr_ptr_reg),
    .wr_data(push_char),
    .rd_addr(head_addr),
    .rd_data(head_char)
  );

  // ---------------------------------------------------------------
  // registered outputs
  // ---------------------------------------------------------------
  wire [1:0] count_next = count_reg + {1'b0, push} - {1'b0, pop};

  // status bits of both entries kept beside the store, so the flags leave resettable flops
  reg [2:0] stat0_reg;
  reg [2:0] stat1_reg;
  wire [2:0] stat_head = head_addr ? stat1_reg : stat0_reg;
  wire [2:0] stat_next = (push && wr_ptr_reg == head_addr) ? push_char[11:9] : stat_head;
  always @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      stat0_reg <= 3'h0;
      stat1_reg <= 3'h0;
    end else if (push) begin
      if (wr_ptr_reg) begin
        stat1_reg <= push_char[11:9];
      end else begin
        stat0_reg <= push_char[11:9];
      end
    end
  end

  // status and data follow the buffer head; no software write path
  always @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      RX_COMPLETE_FLAG <= 1'b0;
      RX_COMPLETE_IRQ <= 1'b0;
      PIN_OVERRIDE <= 1'b0;
      FRAME_ERROR_FLAG <= 1'b0;
      OVERRUN_FLAG <= 1'b0;
      PARITY_ERROR_FLAG <= 1'b0;
    end else begin
      RX_COMPLETE_FLAG <= RECEIVER_ENABLE && count_next != 2'h0;
      RX_COMPLETE_IRQ <= RECEIVER_ENABLE && count_next != 2'h0 && RX_COMPLETE_IRQ_ENABLE;
      PIN_OVERRIDE <= RECEIVER_ENABLE;
      FRAME_ERROR_FLAG <= stat_next[2];
      OVERRUN_FLAG <= stat_next[1];
      PARITY_ERROR_FLAG <= stat_next[0] & par_on;
    end
  end
  // data comes straight from the store's read register
  always @* begin
    DATA_BUFFER_PORT = head_char[8:0];
  end

endmodule

// file: verification/async_rx_chk.sv
// port assertions for the serial receiver
`timescale 1ns/1ps
module async_rx_chk (
  // clock and reset
  input wire CORE_CLK,
  input wire RST,
  // control
  input wire RECEIVER_ENABLE,
  input wire RX_COMPLETE_IRQ_ENABLE,
  input wire [1:0] PARITY_MODE_BITS,
  input wire DATA_READ,
  // status
  input wire PIN_OVERRIDE,
  input wire [8:0] DATA_BUFFER_PORT,
  input wire RX_COMPLETE_FLAG,
  input wire FRAME_ERROR_FLAG,
  input wire PARITY_ERROR_FLAG,
  input wire RX_COMPLETE_IRQ
);
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (RST);
  // request follows flag and enable, one register stage allowed
  irq_on_a: assert property ((RX_COMPLETE_FLAG && RX_COMPLETE_IRQ_ENABLE) [*2] |-> RX_COMPLETE_IRQ)
    else $error("irq low with flag and enable set");
  irq_no_char_a: assert property ((!RX_COMPLETE_FLAG) [*2] |-> !RX_COMPLETE_IRQ)
    else $error("irq high with empty buffer");
  // disable empties buffer and frees the pin
  rx_flush_a: assert property ((!RECEIVER_ENABLE) [*2] |-> !RX_COMPLETE_FLAG)
    else $error("flag kept while disabled");
  pin_release_a: assert property ((!RECEIVER_ENABLE) [*2] |-> !PIN_OVERRIDE)
    else $error("pin held while disabled");
  pin_owned_a: assert property ((RECEIVER_ENABLE && !RST) [*2] |-> PIN_OVERRIDE)
    else $error("pin not taken while enabled");
  parity_off_a: assert property (!PARITY_MODE_BITS[1] |=> !PARITY_ERROR_FLAG)
    else $error("parity error with checking off");
  // head entry stands until a read pops it
  flag_hold_a: assert property (RX_COMPLETE_FLAG && RECEIVER_ENABLE && !DATA_READ && !$past(DATA_READ)
    |=> RX_COMPLETE_FLAG) else $error("flag dropped without read");
  head_stable_a: assert property (RX_COMPLETE_FLAG && RECEIVER_ENABLE && !DATA_READ && !$past(DATA_READ)
    |=> $stable(DATA_BUFFER_PORT) && $stable(FRAME_ERROR_FLAG)) else $error("head changed without read");
endmodule
bind async_serial_receiver async_rx_chk chk (.CORE_CLK, .RST, .RECEIVER_ENABLE, .RX_COMPLETE_IRQ_ENABLE,
  .PARITY_MODE_BITS, .DATA_READ, .PIN_OVERRIDE, .DATA_BUFFER_PORT, .RX_COMPLETE_FLAG, .FRAME_ERROR_FLAG,
  .PARITY_ERROR_FLAG, .RX_COMPLETE_IRQ);

// file: verification/serial_tx_model.sv
// remote serial transmitter model on the receive line
`timescale 1ns/1ps
module serial_tx_model (
  // clock
  input wire clk,
  // serial line, idle high
  output reg line
);
  integer k;
  initial line = 1'b1;
  // hold one level for a number of clocks
  task put(input v, input integer n);
    begin
      line <= v;
      repeat (n) @(posedge clk);
    end
  endtask
  // start, data lsb first, optional parity, one stop; a low stop gets one idle bit after it
  task send(input [8:0] d, input integer nb, input par_on, input par_v, input stop_v, input integer bc);
    begin
      put(1'b0, bc);
      for (k = 0; k < nb; k = k + 1) put(d[k], bc);
      if (par_on) put(par_v, bc);
      put(stop_v, bc);
      if (!stop_v) put(1'b1, bc);
    end
  endtask
endmodule

// file: verification/tb_top.sv
// self-checking bench for the serial receiver
`timescale 1ns/1ps
module tb_top;
  reg core_clk, rst, rx_en, irq_en, dbl, stop_sel, rd, bad, stp;
  reg [1:0] par_mode;
  reg [3:0] nbits;
  reg [8:0] d;
  reg [8:0] q [0:3];
  wire line, pin_ovr, flag, fe, ovr, pe, irq;
  wire [8:0] dout;
  integer miscompares, samples_checked, seed, i, t;
  async_serial_receiver uut (.CORE_CLK(core_clk), .RST(rst), .SERIAL_IN_PIN(line), .PIN_OVERRIDE(pin_ovr),
    .RECEIVER_ENABLE(rx_en), .RX_COMPLETE_IRQ_ENABLE(irq_en), .DOUBLE_SPEED_SELECT(dbl),
    .PARITY_MODE_BITS(par_mode), .STOP_BITS_SELECT(stop_sel), .DATA_BITS(nbits), .BAUD_DIVISOR(16'h0001),
    .DATA_READ(rd), .DATA_BUFFER_PORT(dout), .RX_COMPLETE_FLAG(flag), .FRAME_ERROR_FLAG(fe),
    .OVERRUN_FLAG(ovr), .PARITY_ERROR_FLAG(pe), .RX_COMPLETE_IRQ(irq));
  serial_tx_model tx (.clk(core_clk), .line(line));
  // 100 MHz clock
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  // data bits kept, upper bits read as zero
  function [8:0] keep(input [8:0] v, input [3:0] n);
    keep = v & ((9'h001 << n) - 9'h001);
  endfunction
  // parity bit a correct sender puts out
  function par_of(input [8:0] v, input [3:0] n, input odd);
    par_of = (^keep(v, n)) ^ odd;
  endfunction
  // counts and verdict
  task conclude;
    begin
      $display("checks %0d mismatches %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
    end
  endtask
  // single status bit compare
  task check_bit(input [79:0] name, input exp, input got);
    begin
      samples_checked = samples_checked + 1;
      if (got !== exp) begin
        miscompares = miscompares + 1;
        $display("[FAIL] %0s expected %b seen %b", name, exp, got);
      end
    end
  endtask
  // received character compare
  task check_data(input [8:0] exp, input [8:0] got);
    begin
      samples_checked = samples_checked + 1;
      if (got !== exp) begin
        miscompares = miscompares + 1;
        $display("[FAIL] data expected %h seen %h", exp, got);
      end
    end
  endtask
  // bounded wait for a buffered character
  task wait_flag;
    begin
      t = 0;
      do begin
        @(posedge core_clk);
        #1 t = t + 1;
      end while (flag !== 1'b1 && t < 3000);
      if (t >= 3000) begin
        miscompares = miscompares + 1;
        conclude;
      end
    end
  endtask
  // one-cycle read pulse, then let the next entry settle
  task pop;
    begin
      @(posedge core_clk);
      rd <= 1'b1;
      @(posedge core_clk);
      rd <= 1'b0;
      repeat (4) @(posedge core_clk);
      #1;
    end
  endtask
  // send a frame with current settings; bit is 16 or 8 ticks of 2 clocks
  task frame(input [8:0] v, input s, input b);
    tx.send(v, nbits, par_mode[1], par_of(v, nbits, par_mode[0]) ^ b, s, dbl ? 16 : 32);
  endtask
  // wait, compare head entry, pop
  task expect_char(input [8:0] v, input f, input o, input p);
    begin
      wait_flag;
      check_data(keep(v, nbits), dout);
      check_bit("frame_err", f, fe);
      check_bit("overrun", o, ovr);
      check_bit("parity_err", p, pe);
      pop;
    end
  endtask
  // main sequence
  initial begin
    seed = 4;
    miscompares = 0;
    samples_checked = 0;
    {rst, rx_en, irq_en, dbl, stop_sel, rd, bad, stp} = 8'hc0;
    par_mode = 2'h0;
    nbits = 4'h8;
    d = 9'h000;
    repeat (12) @(posedge core_clk);
    rst <= 1'b0;
    repeat (4) @(posedge core_clk);
    // random frames; first ones walk every parity code with a bad bit and the width limits
    for (i = 0; i < 24; i = i + 1) begin
      dbl <= $random(seed);
      par_mode <= (i < 4) ? i : $random(seed);
      stop_sel <= $random(seed);
      nbits <= (i == 0) ? 4'h5 : (i == 1) ? 4'h9 : 4'h5 + {$random(seed)} % 5;
      d = $random(seed);
      bad = (i < 4) | $random(seed);
      stp = (i != 4) && (($random(seed) & 3) != 0);
      @(posedge core_clk);
      frame(d, stp, bad);
      expect_char(d, !stp, 1'b0, par_mode[1] & bad);
    end
    // parity status reads zero while checking is off, returns with it
    {par_mode, nbits, dbl} <= {2'h2, 4'h8, 1'b0};
    @(posedge core_clk);
    frame(9'h0a5, 1'b1, 1'b1);
    wait_flag;
    par_mode <= 2'h0;
    @(posedge core_clk);
    #1 check_bit("parity_off", 1'b0, pe);
    par_mode <= 2'h2;
    @(posedge core_clk);
    #1 check_bit("parity_on", 1'b1, pe);
    pop;
    // short low pulse is rejected as noise
    tx.put(1'b0, 6);
    tx.put(1'b1, 300);
    #1 check_bit("noise", 1'b0, flag);
    // four frames back to back, no reads, then read until empty
    irq_en <= 1'b1;
    stop_sel <= 1'b1;
    for (i = 0; i < 4; i = i + 1) begin
      q[i] = $random(seed);
      frame(q[i], 1'b1, 1'b0);
    end
    repeat (40) @(posedge core_clk);
    #1 check_bit("irq", 1'b1, irq);
    expect_char(q[0], 1'b0, 1'b0, 1'b0);
    expect_char(q[1], 1'b0, 1'b0, 1'b0);
    expect_char(q[2], 1'b0, 1'b1, 1'b0);
    check_bit("flushed", 1'b0, flag);
    check_bit("irq_off", 1'b0, irq);
    frame(q[3], 1'b1, 1'b0);
    expect_char(q[3], 1'b0, 1'b0, 1'b0);
    // disable drops stored data and abandons a frame in flight
    frame(q[0], 1'b1, 1'b0);
    wait_flag;
    fork
      frame(q[1], 1'b1, 1'b0);
      begin
        repeat (100) @(posedge core_clk);
        rx_en <= 1'b0;
        #21 check_bit("flush", 1'b0, flag);
        check_bit("pin_free", 1'b0, pin_ovr);
      end
    join
    rx_en <= 1'b1;
    repeat (100) @(posedge core_clk);
    #1 check_bit("abandon", 1'b0, flag);
    frame(q[2], 1'b1, 1'b0);
    expect_char(q[2], 1'b0, 1'b0, 1'b0);
    conclude;
  end
endmodule
